// File: rtl/ept_consts.svh
// constants for the five-channel encoder position tracker
// assumes inclusion by rtl files that need sizes, divider counts and resets
`ifndef EPT_CONSTS_SVH
`define EPT_CONSTS_SVH

// ****************************************
// channel and word sizes
// ****************************************
`define EPT_NCH 5
`define EPT_CH_W 3
`define EPT_WORD_W 32
`define EPT_WORD_ZERO 32'h0000_0000
`define EPT_WORD_ONE 32'h0000_0001
`define EPT_NCH_LIMIT 3'h5

// ****************************************
// time signal generator
// ****************************************
// the fast reference rate and the generated rates, in hertz
`define EPT_REF_FAST_HZ 10000
`define EPT_OUT_1K_HZ 1000
`define EPT_OUT_200_HZ 200
`define EPT_OUT_1_HZ 1
// fast-reference pulses per half period of each output
`define EPT_HALF_1K (`EPT_REF_FAST_HZ / (2 * `EPT_OUT_1K_HZ))
`define EPT_HALF_200 (`EPT_REF_FAST_HZ / (2 * `EPT_OUT_200_HZ))
`define EPT_HALF_1 (`EPT_REF_FAST_HZ / (2 * `EPT_OUT_1_HZ))
`define EPT_DIV_W 13
`define EPT_DIV_ZERO 13'h0000
`define EPT_DIV_ONE 13'h0001

`endif

// File: rtl/ept_pkg.sv
// types shared by the encoder position tracker
// assumes ept_consts.svh is on the include path
`include "ept_consts.svh"

package ept_pkg;

    // position word carried by counters and latches
    typedef logic [`EPT_WORD_W-1:0] ept_word_t;

    // divider counter type
    typedef logic [`EPT_DIV_W-1:0] ept_div_t;

    // time generator phase: held until the first second mark
    typedef enum logic {
        EPT_GEN_WAIT,
        EPT_GEN_RUN
    } ept_gen_e;

endpackage : ept_pkg

// File: rtl/ept_tracker_top.sv
// five-channel quadrature position tracker with time signal generator
// assumes quadrature, index and time reference pins are asynchronous;
// host strobes and read requests come from logic on CLK
`timescale 1ns/1ps
`default_nettype none
`include "ept_consts.svh"

module ept_tracker_top
    import ept_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // encoder and index sensor pins
    input wire logic [`EPT_NCH-1:0] QUAD_A,
    input wire logic [`EPT_NCH-1:0] QUAD_B,
    input wire logic [`EPT_NCH-1:0] INDEX_PULSE,
    // external time references
    input wire logic REF_1HZ,
    input wire logic REF_10KHZ,
    // host side, on CLK
    input wire logic [`EPT_NCH-1:0] COUNTER_CLEAR,
    input wire logic [`EPT_NCH-1:0] INDEX_STATUS_CLEAR,
    input wire logic READ_REQ,
    input wire logic [`EPT_CH_W-1:0] READ_CHANNEL,
    input wire logic LATCH_READ_SELECT,
    output logic [`EPT_WORD_W-1:0] READ_DATA,
    output logic READ_VALID,
    output logic [`EPT_NCH-1:0] INDEX_STATUS,
    // generated clocks and notification
    output logic CLK_200HZ,
    output logic CLK_1KHZ,
    output logic CLK_1HZ,
    output logic TICK_200HZ
);

    // ****************************************
    // shared signals
    // ****************************************
    ept_word_t cnt [0:`EPT_NCH-1];
    ept_word_t rel_latch [0:`EPT_NCH-1];
    ept_word_t idx_latch [0:`EPT_NCH-1];
    logic [`EPT_NCH-1:0] idx_event;
    logic latch_strobe;

    // ****************************************
    // per-channel decoder and tracker
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `EPT_NCH; g = g + 1) begin : g_ch
            logic a_s1, a_s2, a_d;
            logic b_s1, b_s2, b_d;
            logic i_s1, i_s2, i_d;
            logic cnt_pulse, cnt_up;
            wire a_edge;
            wire b_edge;
            wire next_pulse;
            wire next_up;

            // edge of exactly one input is a valid quadrature step;
            // both at once is a lost phase and is dropped
            assign a_edge = a_s2 ^ a_d;
            assign b_edge = b_s2 ^ b_d;
            assign next_pulse = a_edge ^ b_edge;
            assign next_up = a_d ^ b_s2; // up when b leads a

            // two-flop synchronisers, then one delay for edge detect
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    a_s1 <= 1'b0;
                    a_s2 <= 1'b0;
                    a_d <= 1'b0;
                    b_s1 <= 1'b0;
                    b_s2 <= 1'b0;
                    b_d <= 1'b0;
                    i_s1 <= 1'b0;
                    i_s2 <= 1'b0;
                    i_d <= 1'b0;
                end else begin
                    a_s1 <= QUAD_A[g];
                    a_s2 <= a_s1;
                    a_d <= a_s2;
                    b_s1 <= QUAD_B[g];
                    b_s2 <= b_s1;
                    b_d <= b_s2;
                    i_s1 <= INDEX_PULSE[g];
                    i_s2 <= i_s1;
                    i_d <= i_s2;
                end
            end

            // index latches on the rising edge of the sensor pulse
            assign idx_event[g] = i_s2 & ~i_d;

            // decoder outputs handed to the tracker
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    cnt_pulse <= 1'b0;
                    cnt_up <= 1'b0;
                end else begin
                    cnt_pulse <= next_pulse;
                    cnt_up <= next_up;
                end
            end

            // counter: clear beats count; one step per clock is
            // far above the 5 MHz pulse rate
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    cnt[g] <= `EPT_WORD_ZERO;
                end else if (COUNTER_CLEAR[g]) begin
                    cnt[g] <= `EPT_WORD_ZERO;
                end else if (cnt_pulse) begin
                    cnt[g] <= cnt_up ? cnt[g] + `EPT_WORD_ONE
                                     : cnt[g] - `EPT_WORD_ONE;
                end
            end

            // latches sample the registered counter, never mid-change
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    rel_latch[g] <= `EPT_WORD_ZERO;
                    idx_latch[g] <= `EPT_WORD_ZERO;
                end else begin
                    if (latch_strobe) begin
                        rel_latch[g] <= cnt[g];
                    end
                    if (idx_event[g]) begin
                        idx_latch[g] <= cnt[g];
                    end
                end
            end

            // status: a new index wins over a clear in the same cycle
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    INDEX_STATUS[g] <= 1'b0;
                end else if (idx_event[g]) begin
                    INDEX_STATUS[g] <= 1'b1;
                end else if (INDEX_STATUS_CLEAR[g]) begin
                    INDEX_STATUS[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // host read port
    // ****************************************
    // a read in the cycle of a strobe sees the word from before it;
    // latch update and read never race inside one cycle
    wire ch_ok;
    wire [`EPT_WORD_W-1:0] sel_word;
    assign ch_ok = READ_CHANNEL < `EPT_NCH_LIMIT;
    assign sel_word = !ch_ok ? `EPT_WORD_ZERO
                    : LATCH_READ_SELECT ? idx_latch[READ_CHANNEL]
                    : rel_latch[READ_CHANNEL];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            READ_DATA <= `EPT_WORD_ZERO;
            READ_VALID <= 1'b0;
        end else begin
            READ_VALID <= READ_REQ;
            if (READ_REQ) begin
                READ_DATA <= sel_word;
            end
        end
    end

    // ****************************************
    // time signal generator
    // ****************************************
    logic s1_s1, s1_s2, s1_d;
    logic f_s1, f_s2, f_d;
    ept_gen_e gen_state;
    ept_div_t div_1k, div_200, div_1;
    logic next_1k, next_200, next_1hz;
    ept_div_t next_div_1k, next_div_200, next_div_1;
    ept_gen_e next_gen_state;
    wire sec_edge;
    wire fast_edge;

    // reference pulses are short and asynchronous
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s1_s1 <= 1'b0;
            s1_s2 <= 1'b0;
            s1_d <= 1'b0;
            f_s1 <= 1'b0;
            f_s2 <= 1'b0;
            f_d <= 1'b0;
        end else begin
            s1_s1 <= REF_1HZ;
            s1_s2 <= s1_s1;
            s1_d <= s1_s2;
            f_s1 <= REF_10KHZ;
            f_s2 <= f_s1;
            f_d <= f_s2;
        end
    end

    assign sec_edge = s1_s2 & ~s1_d;
    assign fast_edge = f_s2 & ~f_d;

    // dividers count fast pulses; each half period toggles an output
    always_comb begin
        next_gen_state = gen_state;
        next_div_1k = div_1k;
        next_div_200 = div_200;
        next_div_1 = div_1;
        next_1k = CLK_1KHZ;
        next_200 = CLK_200HZ;
        next_1hz = CLK_1HZ;
        case (gen_state)
            EPT_GEN_WAIT: begin
                if (sec_edge) begin
                    next_gen_state = EPT_GEN_RUN;
                    next_div_1k = `EPT_DIV_ZERO;
                    next_div_200 = `EPT_DIV_ZERO;
                    next_div_1 = `EPT_DIV_ZERO;
                    next_1k = 1'b1;
                    next_200 = 1'b1;
                    next_1hz = 1'b1;
                end
            end
            EPT_GEN_RUN: begin
                if (sec_edge) begin
                    next_div_1k = `EPT_DIV_ZERO;
                    next_div_200 = `EPT_DIV_ZERO;
                    next_div_1 = `EPT_DIV_ZERO;
                    next_1k = 1'b1;
                    next_200 = 1'b1;
                    next_1hz = 1'b1;
                end else if (fast_edge) begin
                    if (div_1k == 13'(`EPT_HALF_1K - 1)) begin
                        next_div_1k = `EPT_DIV_ZERO;
                        next_1k = ~CLK_1KHZ;
                    end else begin
                        next_div_1k = div_1k + `EPT_DIV_ONE;
                    end
                    if (div_200 == 13'(`EPT_HALF_200 - 1)) begin
                        next_div_200 = `EPT_DIV_ZERO;
                        next_200 = ~CLK_200HZ;
                    end else begin
                        next_div_200 = div_200 + `EPT_DIV_ONE;
                    end
                    if (div_1 == 13'(`EPT_HALF_1 - 1)) begin
                        next_div_1 = `EPT_DIV_ZERO;
                        next_1hz = ~CLK_1HZ;
                    end else begin
                        next_div_1 = div_1 + `EPT_DIV_ONE;
                    end
                end
            end
            default: begin
                next_gen_state = EPT_GEN_WAIT;
            end
        endcase
    end

    // a restart that lands on a natural rising edge gives one strobe
    assign latch_strobe = TICK_200HZ;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            gen_state <= EPT_GEN_WAIT;
            div_1k <= `EPT_DIV_ZERO;
            div_200 <= `EPT_DIV_ZERO;
            div_1 <= `EPT_DIV_ZERO;
            CLK_1KHZ <= 1'b0;
            CLK_200HZ <= 1'b0;
            CLK_1HZ <= 1'b0;
            TICK_200HZ <= 1'b0;
        end else begin
            gen_state <= next_gen_state;
            div_1k <= next_div_1k;
            div_200 <= next_div_200;
            div_1 <= next_div_1;
            CLK_1KHZ <= next_1k;
            CLK_200HZ <= next_200;
            CLK_1HZ <= next_1hz;
            TICK_200HZ <= next_200 & ~CLK_200HZ;
        end
    end

endmodule // ept_tracker_top
`default_nettype wire

// File: tb/ept_tracker_checker.sv
// concurrent checks on the tracker top ports
// assumes binding onto ept_tracker_top, one CLK domain
`timescale 1ns/1ps
`default_nettype none
`include "ept_consts.svh"
// ********
// port checker
// ********
module ept_tracker_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // host side
    input wire logic READ_REQ,
    input wire logic [`EPT_CH_W-1:0] READ_CHANNEL,
    input wire logic [`EPT_WORD_W-1:0] READ_DATA,
    input wire logic READ_VALID,
    input wire logic [`EPT_NCH-1:0] INDEX_STATUS_CLEAR,
    input wire logic [`EPT_NCH-1:0] INDEX_STATUS,
    // generated clocks
    input wire logic CLK_200HZ,
    input wire logic CLK_1KHZ,
    input wire logic CLK_1HZ,
    input wire logic TICK_200HZ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // a read is answered on the very next edge
    sequence s_answer;
        ##1 READ_VALID;
    endsequence
    a_read_answer: assert property (READ_REQ |-> s_answer)
        else $error("read not answered");
    a_no_stray: assert property (!READ_REQ |=> !READ_VALID)
        else $error("valid without request");
    a_data_holds: assert property (!READ_REQ |=> $stable(READ_DATA))
        else $error("read data moved");
    a_bad_channel: assert property ((READ_REQ && READ_CHANNEL >= 3'h5)
        |=> READ_DATA == 32'h0)
        else $error("bad channel not zero");
    // a status bit only drops when its clear was given
    a_status_sticky: assert property (1'b1 |=> ((INDEX_STATUS
        | ~$past(INDEX_STATUS) | $past(INDEX_STATUS_CLEAR)) == 5'h1f))
        else $error("status bit lost");
    a_tick_edge: assert property (TICK_200HZ == $rose(CLK_200HZ))
        else $error("tick not on 200 Hz rise");
    a_1k_aligned: assert property ($rose(CLK_200HZ) |-> $rose(CLK_1KHZ))
        else $error("1 kHz not aligned");
    a_1hz_aligned: assert property ($rose(CLK_1HZ) |-> $rose(CLK_200HZ))
        else $error("200 Hz not aligned");
endmodule // ept_tracker_checker

bind ept_tracker_top ept_tracker_checker ept_tracker_checker_i (
    .CLK(CLK), .RESET(RESET), .READ_REQ(READ_REQ),
    .READ_CHANNEL(READ_CHANNEL), .READ_DATA(READ_DATA),
    .READ_VALID(READ_VALID), .INDEX_STATUS_CLEAR(INDEX_STATUS_CLEAR),
    .INDEX_STATUS(INDEX_STATUS), .CLK_200HZ(CLK_200HZ),
    .CLK_1KHZ(CLK_1KHZ), .CLK_1HZ(CLK_1HZ), .TICK_200HZ(TICK_200HZ)
);
`default_nettype wire

// File: tb/ept_quad_model.sv
// quadrature encoder model for the five tracker channels
// assumes step requests at least four clk cycles apart
`timescale 1ns/1ps
`default_nettype none
// ********
// encoder model
// ********
module ept_quad_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // step request
    input wire logic step,
    input wire logic up,
    input wire logic [2:0] ch,
    // quadrature pins
    output logic [4:0] quad_a,
    output logic [4:0] quad_b
);
    logic [1:0] phase [5];
    // gray steps, so only one pin moves per step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= '{default: 2'h0};
        end else if (step) begin
            phase[ch] <= up ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
        end
    end
    // b leads a when stepping up, the sense the tracker counts up
    for (genvar g = 0; g < 5; g++) begin : g_pin
        assign quad_a[g] = phase[g][1];
        assign quad_b[g] = phase[g][0] ^ phase[g][1];
    end
endmodule // ept_quad_model
`default_nettype wire

// File: tb/ept_tracker_top_tb.sv
// self-checking bench for the five-channel position tracker
// assumes model and checker compiled first; refs run fast
`timescale 1ns/1ps
`default_nettype none
`include "ept_consts.svh"
// ********
// bench top
// ********
module ept_tracker_top_tb;
    import ept_pkg::*;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [4:0] INDEX_PULSE = 5'h00;
    logic REF_1HZ = 1'b0;
    logic REF_10KHZ = 1'b0;
    logic [4:0] COUNTER_CLEAR = 5'h00;
    logic [4:0] INDEX_STATUS_CLEAR = 5'h00;
    logic READ_REQ = 1'b0;
    logic [2:0] READ_CHANNEL = 3'h0;
    logic LATCH_READ_SELECT = 1'b0;
    logic step = 1'b0;
    logic step_up = 1'b0;
    logic [2:0] step_ch = 3'h0;
    logic ref_on = 1'b0;
    logic [2:0] ref_ph = 3'h0;
    logic [4:0] QUAD_A;
    logic [4:0] QUAD_B;
    ept_word_t READ_DATA;
    logic READ_VALID;
    logic [4:0] INDEX_STATUS;
    logic CLK_200HZ;
    logic CLK_1KHZ;
    logic CLK_1HZ;
    logic TICK_200HZ;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h5868;
    int n;
    ept_word_t cnt [5];
    ept_word_t idx_word;
    ept_word_t exp_q [$];

    ept_tracker_top ept_tracker_top_i (.CLK(CLK), .RESET(RESET),
        .QUAD_A(QUAD_A), .QUAD_B(QUAD_B), .INDEX_PULSE(INDEX_PULSE),
        .REF_1HZ(REF_1HZ), .REF_10KHZ(REF_10KHZ),
        .COUNTER_CLEAR(COUNTER_CLEAR),
        .INDEX_STATUS_CLEAR(INDEX_STATUS_CLEAR), .READ_REQ(READ_REQ),
        .READ_CHANNEL(READ_CHANNEL), .LATCH_READ_SELECT(LATCH_READ_SELECT),
        .READ_DATA(READ_DATA), .READ_VALID(READ_VALID),
        .INDEX_STATUS(INDEX_STATUS), .CLK_200HZ(CLK_200HZ),
        .CLK_1KHZ(CLK_1KHZ), .CLK_1HZ(CLK_1HZ), .TICK_200HZ(TICK_200HZ));
    ept_quad_model ept_quad_model_i (.clk(CLK), .rst(RESET), .step(step),
        .up(step_up), .ch(step_ch), .quad_a(QUAD_A), .quad_b(QUAD_B));

    always #2.5 CLK = ~CLK;
    // fast reference sped up: 3 of 8 cycles high, keeps runs short
    always @(posedge CLK) begin
        if (ref_on) begin
            ref_ph <= ref_ph + 3'h1;
            REF_10KHZ <= (ref_ph < 3'h3);
        end
    end
    // hang guard
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            $display("ERROR run expected done seen hang");
            wrap_up();
        end
    end
    // monitor takes the oldest expected word on every answer
    always @(posedge CLK) begin
        if (READ_VALID === 1'b1) begin
            check("read_data", READ_DATA, exp_q.pop_front());
        end
    end

    task automatic check(input string nm, input ept_word_t seen,
        input ept_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [2:0] ch, input logic sel,
        input ept_word_t e);
        READ_REQ <= 1'b1;
        READ_CHANNEL <= ch;
        LATCH_READ_SELECT <= sel;
        exp_q.push_back(e);
        @(posedge CLK);
        READ_REQ <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic mv(input logic [2:0] ch, input logic up);
        step <= 1'b1;
        step_ch <= ch;
        step_up <= up;
        @(posedge CLK);
        step <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask
    // let the last step settle so the latch cannot miss it
    task automatic wait_tick;
        repeat (6) @(posedge CLK);
        while (TICK_200HZ !== 1'b1) @(posedge CLK);
        repeat (2) @(posedge CLK);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        rd(3'h0, 1'b0, 32'h0);
        rd(3'h4, 1'b1, 32'h0);
        check("clk_200hz", ept_word_t'(CLK_200HZ), 32'h0);
        $display("test reset done");
        REF_1HZ <= 1'b1;
        repeat (3) @(posedge CLK);
        REF_1HZ <= 1'b0;
        ref_on <= 1'b1;
        repeat (4) @(posedge CLK);
        check("clk_1khz", ept_word_t'(CLK_1KHZ), 32'h1);
        check("clk_1hz", ept_word_t'(CLK_1HZ), 32'h1);
        // half period of 1 kHz is five fast pulses, 8 cycles apart here
        repeat (32) @(posedge CLK);
        check("clk_1khz", ept_word_t'(CLK_1KHZ), 32'h1);
        @(posedge CLK);
        check("clk_1khz", ept_word_t'(CLK_1KHZ), 32'h0);
        $display("test generator done");
        for (int k = 0; k < 5; k++) begin
            n = ($random(seed) & 31) + 1;
            repeat (n) mv(3'(k), 1'b1);
            cnt[k] = ept_word_t'(n);
            n = $random(seed) & 63;
            repeat (n) mv(3'(k), 1'b0);
            cnt[k] = cnt[k] - ept_word_t'(n);
        end
        wait_tick();
        for (int k = 0; k < 5; k++) rd(3'(k), 1'b0, cnt[k]);
        $display("test counting done");
        INDEX_PULSE <= 5'h04;
        repeat (3) @(posedge CLK);
        INDEX_PULSE <= 5'h00;
        repeat (6) @(posedge CLK);
        check("index_status", ept_word_t'(INDEX_STATUS), 32'h4);
        rd(3'h2, 1'b1, cnt[2]);
        idx_word = READ_DATA;
        repeat (3) mv(3'h2, 1'b1);
        wait_tick();
        rd(3'h2, 1'b0, cnt[2] + 32'h3);
        check("absolute", READ_DATA - idx_word, 32'h3);
        INDEX_STATUS_CLEAR <= 5'h04;
        @(posedge CLK);
        INDEX_STATUS_CLEAR <= 5'h00;
        repeat (2) @(posedge CLK);
        check("index_status", ept_word_t'(INDEX_STATUS), 32'h0);
        $display("test index done");
        COUNTER_CLEAR <= 5'h1f;
        @(posedge CLK);
        COUNTER_CLEAR <= 5'h00;
        wait_tick();
        for (int k = 0; k < 5; k++) rd(3'(k), 1'b0, 32'h0);
        rd(3'h2, 1'b1, cnt[2]);
        for (int k = 5; k < 8; k++) rd(3'(k), 1'b1, 32'h0);
        repeat (4) @(posedge CLK);
        $display("test clear done");
        wrap_up();
    end
endmodule // ept_tracker_top_tb
`default_nettype wire
